// ### hw/asr_pkg.sv
package asr_pkg;
   localparam int DIV_W = 16;
   localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
   localparam int OVS_LOW = 64;
   localparam int OVS_HIGH = 16;
   localparam int OVS_W16_LOW = 16;
   localparam int OVS_W16_HIGH = 4;
   localparam int OVS_W = 8;
   localparam int DATA_W = 8;
   localparam int NINTH_BIT = 8;
   localparam int CNT_W = 4;
endpackage

// ### hw/asr_tick.sv
`timescale 1ns/1ps
`default_nettype none
module asr_tick
   import asr_pkg::*;
#(
   parameter int W = DIV_W
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic run,
   input wire logic [W-1:0] divisor,
   output logic tick
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic tick;
   } asr_tick_st_t;
   asr_tick_st_t s_reg, s_next;
   always_comb begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      if (!run) begin
         s_next.cnt = divisor;
      end else if (s_reg.cnt == '0) begin
         s_next.cnt = divisor;
         s_next.tick = 1'b1;
      end else begin
         s_next.cnt = s_reg.cnt - 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
   assign tick = s_reg.tick;
endmodule
`default_nettype wire

// ### hw/asr_rx.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R01: Baud set by divider high/low pair plus speed and wide selects.
// R02: Port inactive unless serial port enable is set.
// R03: Clocked-mode select must be clear for asynchronous reception.
// R04: Software clears the pin's analog select before receiving.
// R05: Nine-bit enable adds a ninth data bit; otherwise eight bits.
// R06: Characters sampled and assembled only while continuous receive enabled.
// R07: Flag set whenever a completed character enters the buffer.
// R08: Interrupt request is flag gated by receive interrupt enable.
// R09: Status shows error flags and ninth bit of buffered character.
// R10: Buffer read returns low eight data bits of oldest character.
// R11: Clearing continuous receive enable clears the overrun flag.
// R12: Address detection is used with nine-bit reception enabled.
// R13: Address detect enable switches receiver into address mode.
// R14: In address mode only ninth-bit-one characters are buffered.
// R15: In address mode buffered ninth bit always reads one.
// R16: Software compares addresses; hardware performs no matching.
// R17: Clearing address detect lets every character into the buffer.
// R18: Low start, LSB first data, optional ninth, high stop; low stop frames error.
// R19: Completion with full buffer sets overrun and halts transfers until cleared.
module asr_rx
   import asr_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic RX_PIN,
   input wire logic [7:0] BAUD_DIVIDER_HIGH,
   input wire logic [7:0] BAUD_DIVIDER_LOW,
   input wire logic HIGH_SPEED_BAUD_SELECT,
   input wire logic WIDE_BAUD_DIVIDER_SELECT,
   input wire logic SERIAL_PORT_ENABLE,
   input wire logic CLOCKED_MODE_SELECT,
   input wire logic NINE_BIT_RECEIVE_ENABLE,
   input wire logic CONTINUOUS_RECEIVE_ENABLE,
   input wire logic ADDRESS_DETECT_ENABLE,
   input wire logic RECEIVE_INTERRUPT_ENABLE,
   input wire logic BUFFER_READ,
   output logic [DATA_W-1:0] RECEIVE_BUFFER,
   output logic NINTH_DATA_BIT,
   output logic FRAMING_ERROR,
   output logic OVERRUN_FLAG,
   output logic RECEIVE_INTERRUPT_FLAG,
   output logic RECEIVE_IRQ,
   output logic PORT_ACTIVE
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_START = 2'b01,
      ST_DATA = 2'b10,
      ST_STOP = 2'b11
   } asr_state_t;
   typedef struct packed {
      logic rx_s1;
      logic rx_s2;
      asr_state_t state;
      logic [OVS_W-1:0] phase;
      logic [CNT_W-1:0] bit_cnt;
      logic [NINTH_BIT:0] receive_shift_register;
      logic [DATA_W-1:0] buf_data;
      logic buf_ninth;
      logic buf_ferr;
      logic full;
      logic overrun;
      logic irq;
      logic irq_out;
      logic active;
   } asr_st_t;
   asr_st_t s_reg, s_next;
   logic run;
   logic tick;
   logic [OVS_W-1:0] ovs;
   logic [CNT_W-1:0] nbits;
   logic accept;
   // Port owns pin only when enabled and asynchronous
   assign run = SERIAL_PORT_ENABLE && !CLOCKED_MODE_SELECT; // R02
   // R01
   asr_tick #(.W(DIV_W)) u_tick (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .run(run),
      .divisor({BAUD_DIVIDER_HIGH & {8{WIDE_BAUD_DIVIDER_SELECT}}, BAUD_DIVIDER_LOW}),
      .tick(tick)
   );
   // Divider ticks are subdivided into one bit time
   always_comb begin
      unique case ({WIDE_BAUD_DIVIDER_SELECT, HIGH_SPEED_BAUD_SELECT}) // R01
         2'b00: ovs = OVS_W'(OVS_LOW);
         2'b01: ovs = OVS_W'(OVS_HIGH);
         2'b10: ovs = OVS_W'(OVS_W16_LOW);
         2'b11: ovs = OVS_W'(OVS_W16_HIGH);
      endcase
   end
   assign nbits = NINE_BIT_RECEIVE_ENABLE ? CNT_W'(NINTH_BIT + 1) : CNT_W'(DATA_W); // R05
   // Address mode keeps only frames whose ninth bit is set
   assign accept = !ADDRESS_DETECT_ENABLE ||
      (NINE_BIT_RECEIVE_ENABLE && s_reg.receive_shift_register[NINTH_BIT]); // R13 R14 R17
   always_comb begin
      s_next = s_reg;
      s_next.rx_s1 = RX_PIN;
      s_next.rx_s2 = s_reg.rx_s1;
      s_next.active = run;
      if (BUFFER_READ && s_reg.full) begin
         s_next.full = 1'b0;
         s_next.irq = 1'b0;
      end
      if (!CONTINUOUS_RECEIVE_ENABLE) begin
         s_next.overrun = 1'b0; // R11
      end
      if (!run || !CONTINUOUS_RECEIVE_ENABLE || s_reg.overrun) begin // R06 R19
         s_next.state = ST_IDLE;
         s_next.phase = '0;
      end else if (tick) begin
         s_next.phase = s_reg.phase + 1'b1;
         unique case (s_reg.state)
            ST_IDLE: begin
               s_next.phase = '0;
               if (!s_reg.rx_s2) begin
                  s_next.state = ST_START; // R03
               end
            end
            ST_START: begin
               // Mid-bit check rejects glitches
               if (s_reg.phase == (ovs >> 1) - 1'b1) begin
                  s_next.phase = '0;
                  s_next.bit_cnt = '0;
                  s_next.state = s_reg.rx_s2 ? ST_IDLE : ST_DATA; // R18
               end
            end
            ST_DATA: begin
               if (s_reg.phase == ovs - 1'b1) begin
                  s_next.phase = '0;
                  s_next.receive_shift_register =
                     {s_reg.rx_s2, s_reg.receive_shift_register[NINTH_BIT:1]}; // R18
                  s_next.bit_cnt = s_reg.bit_cnt + 1'b1;
                  if (s_reg.bit_cnt == nbits - 1'b1) begin
                     s_next.state = ST_STOP;
                  end
               end
            end
            ST_STOP: begin
               if (s_reg.phase == ovs - 1'b1) begin
                  s_next.state = ST_IDLE;
                  s_next.phase = '0;
                  // Eight-bit frames leave one shift short
                  if (accept) begin // R12 R14
                     if (s_next.full) begin
                        s_next.overrun = 1'b1; // R19
                     end else begin
                        s_next.full = 1'b1;
                        s_next.irq = 1'b1; // R07
                        s_next.buf_ferr = !s_reg.rx_s2; // R18
                        if (NINE_BIT_RECEIVE_ENABLE) begin
                           s_next.buf_data = s_reg.receive_shift_register[DATA_W-1:0];
                           s_next.buf_ninth = s_reg.receive_shift_register[NINTH_BIT]
                                              || ADDRESS_DETECT_ENABLE; // R15
                        end else begin
                           s_next.buf_data = s_reg.receive_shift_register[NINTH_BIT:1];
                           s_next.buf_ninth = 1'b0;
                        end
                     end
                  end
               end
            end
         endcase
      end
      // Request follows the flag in the same cycle; both are registered from the next state
      s_next.irq_out = s_next.irq && RECEIVE_INTERRUPT_ENABLE; // R08
   end
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         s_reg <= '0;
         s_reg.rx_s1 <= 1'b1;
         s_reg.rx_s2 <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end
   assign RECEIVE_BUFFER = s_reg.buf_data; // R10
   assign NINTH_DATA_BIT = s_reg.buf_ninth; // R09
   assign FRAMING_ERROR = s_reg.buf_ferr; // R09
   assign OVERRUN_FLAG = s_reg.overrun;
   assign RECEIVE_INTERRUPT_FLAG = s_reg.irq;
   assign RECEIVE_IRQ = s_reg.irq_out;
   assign PORT_ACTIVE = s_reg.active;
   a_irq_gate: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R08
      RECEIVE_IRQ |-> $past(RECEIVE_INTERRUPT_ENABLE))
      else $error("irq without enable");
   a_overrun_flag_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R11
      !$past(CONTINUOUS_RECEIVE_ENABLE) |-> !OVERRUN_FLAG)
      else $error("overrun not cleared");
   a_addr_ninth: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R15
      ($rose(RECEIVE_INTERRUPT_FLAG) && $past(ADDRESS_DETECT_ENABLE)) |-> NINTH_DATA_BIT)
      else $error("ninth bit not one");
   a_idle_off: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R06
      !$past(CONTINUOUS_RECEIVE_ENABLE) |-> s_reg.state == ST_IDLE)
      else $error("receiving while disabled");
   a_active: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R02
      PORT_ACTIVE == $past(run))
      else $error("active mismatch");
   a_flag_full: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R07
      $rose(RECEIVE_INTERRUPT_FLAG) |-> s_reg.full)
      else $error("flag without buffer");
   a_overrun_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R19
      (OVERRUN_FLAG && CONTINUOUS_RECEIVE_ENABLE) |=> $stable(RECEIVE_BUFFER))
      else $error("transfer during overrun");
   a_eight_bit: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R05
      ($rose(RECEIVE_INTERRUPT_FLAG) && !$past(NINE_BIT_RECEIVE_ENABLE)) |-> !NINTH_DATA_BIT)
      else $error("ninth bit in eight-bit mode");
   // Stop-bit sample while the receiver may run
   sequence s_frame_end;
      tick && run && CONTINUOUS_RECEIVE_ENABLE && s_reg.state == ST_STOP &&
         s_reg.phase == ovs - 1'b1;
   endsequence
   sequence s_free;
      !s_reg.full || BUFFER_READ;
   endsequence
   sequence s_busy;
      s_reg.full && !BUFFER_READ;
   endsequence
   a_frame_load: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R07 R17
      (s_frame_end ##0 !ADDRESS_DETECT_ENABLE ##0 s_free) |=> RECEIVE_INTERRUPT_FLAG)
      else $error("frame not buffered");
   a_overrun_set: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R19
      (s_frame_end ##0 accept ##0 s_busy) |=> OVERRUN_FLAG)
      else $error("overrun not set");
   a_addr_drop: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R14
      (s_frame_end ##0 (ADDRESS_DETECT_ENABLE && !s_reg.receive_shift_register[NINTH_BIT]))
      |=> !$rose(RECEIVE_INTERRUPT_FLAG))
      else $error("address mode kept a data frame");
endmodule
`default_nettype wire

// ### tb/asr_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module asr_tx_model (
   input wire logic clk,
   output logic line
);
   // Line rests high between frames
   initial line = 1'b1;
   task automatic send(input logic [8:0] ch, input logic nine, input logic stop_ok,
      input int bit_clks);
      logic [11:0] fr;
      int n;
      n = nine ? 12 : 11;
      // Start low, LSB first, optional ninth, stop as asked, then one idle bit
      // Idle bit lets a low stop recover before the next start
      fr = nine ? {1'b1, stop_ok, ch, 1'b0} : {2'b11, stop_ok, ch[7:0], 1'b0};
      for (int i = 0; i < n; i++) begin
         line = fr[i];
         repeat (bit_clks) @(posedge clk);
         #1;
      end
   endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import asr_pkg::*;
   logic clk = 0, rst_b = 0, rx, hs = 1, wd = 1, spe = 0, nine = 0, continuous_receive_enable = 0;
   logic adr = 0, ie = 0, rd = 0, seen = 0, auto_rd = 1, cms = 0;
   logic [7:0] dh = 8'h00, dl = 8'h01;
   logic [DATA_W-1:0] buf_o;
   logic ninth_o, fe_o, ov_o, fl_o, irq_o, act_o;
   logic [31:0] seed = 32'h8B491CAB;
   logic [10:0] q[$];
   logic [10:0] e;
   int n_fail = 0, n_compared = 0, bit_clks = 8;
   always #2 clk = ~clk;
   asr_tx_model tx (.clk(clk), .line(rx));
   asr_rx dut (.SYS_CLK(clk), .RST_B(rst_b), .RX_PIN(rx),
      .BAUD_DIVIDER_HIGH(dh), .BAUD_DIVIDER_LOW(dl), .HIGH_SPEED_BAUD_SELECT(hs),
      .WIDE_BAUD_DIVIDER_SELECT(wd), .SERIAL_PORT_ENABLE(spe), .CLOCKED_MODE_SELECT(cms),
      .NINE_BIT_RECEIVE_ENABLE(nine), .CONTINUOUS_RECEIVE_ENABLE(continuous_receive_enable),
      .ADDRESS_DETECT_ENABLE(adr), .RECEIVE_INTERRUPT_ENABLE(ie), .BUFFER_READ(rd),
      .RECEIVE_BUFFER(buf_o), .NINTH_DATA_BIT(ninth_o), .FRAMING_ERROR(fe_o),
      .OVERRUN_FLAG(ov_o), .RECEIVE_INTERRUPT_FLAG(fl_o), .RECEIVE_IRQ(irq_o),
      .PORT_ACTIVE(act_o));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction
   task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Note goes in before the frame, so the monitor never races it
   task automatic send(input logic [8:0] ch, input logic stop, input logic keep);
      if (keep) q.push_back({ie, ~stop, ch});
      tx.send(ch, nine, stop, bit_clks);
   endtask
   task automatic drain;
      int i;
      for (i = 0; i < 4000 && (q.size() != 0 || seen); i++) @(posedge clk);
      if (i == 4000) begin
         n_fail++;
         $display("[FAIL] drain expected empty seen timeout");
         report_and_stop();
      end
      step(4 * bit_clks);
   endtask
   // Monitor acts as reading software; an unnoted character compares against all ones
   always @(posedge clk) begin
      #1;
      if (rd) begin
         rd = 0;
      end else if (seen && auto_rd) begin
         chk("irq", {10'h000, e[10]}, {10'h000, irq_o});
         rd = 1;
         seen = 0;
      end else if (fl_o === 1'b1 && !seen) begin
         e = (q.size() == 0) ? 11'h7FF : q.pop_front();
         chk("char", {1'b0, e[9:0]}, {1'b0, fe_o, ninth_o, buf_o});
         seen = 1;
      end
   end
   initial begin
      step(10);
      rst_b = 1;
      step(2);
      chk("active", 11'h000, {10'h000, act_o});
      spe = 1;
      step(2);
      chk("active", 11'h001, {10'h000, act_o});
      continuous_receive_enable = 1;
      // Clocked mode must keep the port off and the line ignored
      cms = 1;
      step(2);
      chk("active", 11'h000, {10'h000, act_o});
      send(9'h05A, 1, 0);
      cms = 0;
      step(4);
      ie = 1;
      for (int r = 0; r < 4; r++) begin
         // Passes walk all speed/width pairs; high byte ignored when narrow
         case (r)
            1: begin
               wd = 0;
               dh = 8'h5A;
               dl = 8'h00;
               bit_clks = 16;
               ie = 0;
            end
            2: begin
               wd = 1;
               hs = 0;
               dh = 8'h00;
               bit_clks = 16;
               ie = 1;
            end
            3: begin
               wd = 0;
               bit_clks = 64;
            end
            default: begin
            end
         endcase
         repeat (3) begin
            seed = lfsr(seed);
            send({1'b0, seed[7:0]}, 1, 1);
         end
         drain();
      end
      $display("test eight_bit done");
      wd = 1;
      hs = 1;
      dl = 8'h01;
      bit_clks = 8;
      ie = 1;
      nine = 1;
      repeat (4) begin
         seed = lfsr(seed);
         send(seed[8:0], 1, 1);
      end
      send(9'h0A5, 0, 1);
      drain();
      $display("test nine_bit done");
      adr = 1;
      send(9'h033, 1, 0);
      send(9'h1C4, 1, 1);
      drain();
      adr = 0;
      send(9'h055, 1, 1);
      drain();
      continuous_receive_enable = 0;
      send(9'h1AA, 1, 0);
      drain();
      continuous_receive_enable = 1;
      $display("test address done");
      // Hold the buffer so the second frame lands on a full one
      auto_rd = 0;
      send(9'h111, 1, 1);
      send(9'h122, 1, 0);
      step(4 * bit_clks);
      chk("overrun", 11'h001, {10'h000, ov_o});
      auto_rd = 1;
      step(4);
      send(9'h133, 1, 0);
      step(4 * bit_clks);
      chk("halted flag", 11'h000, {10'h000, fl_o});
      continuous_receive_enable = 0;
      step(3);
      chk("overrun", 11'h000, {10'h000, ov_o});
      continuous_receive_enable = 1;
      send(9'h144, 1, 1);
      drain();
      $display("test overrun done");
      report_and_stop();
   end
endmodule
`default_nettype wire
